/* File: gpmux_defs.svh */
// register offsets, field positions and code values for the pin output mux
`ifndef GPMUX_DEFS_SVH
`define GPMUX_DEFS_SVH

// ------------------------------------------------------------
// register map (printed offsets are register indices)
// ------------------------------------------------------------
`define GPMUX_IDX_PIN3_CTL    8'h13
`define GPMUX_IDX_PIN4_CTL    8'h14
`define GPMUX_IDX_RX_ENABLE   8'h20
`define GPMUX_IDX_TX0_RXSEL   8'h21
`define GPMUX_IDX_TX1_RXSEL   8'h22
`define GPMUX_IDX_PIN_STATUS  8'h23
`define GPMUX_CTL_RESET       8'h00
`define GPMUX_RXEN_RESET      4'hF
`define GPMUX_TXSEL_RESET     4'hF

// ------------------------------------------------------------
// control field positions
// ------------------------------------------------------------
`define GPMUX_SEL_HI          7
`define GPMUX_SEL_LO          5
`define GPMUX_SRC_HI          4
`define GPMUX_SRC_LO          2
`define GPMUX_VAL_BIT         1
`define GPMUX_EN_BIT          0

// ------------------------------------------------------------
// source classes and selectors
// ------------------------------------------------------------
`define GPMUX_SRC_STATUS      3'h4
`define GPMUX_SRC_RSVD        3'h5
`define GPMUX_SEL_LOCK        3'h4
`define GPMUX_SEL_PASS        3'h5
`define GPMUX_SEL_FV          3'h6
`define GPMUX_SEL_LV          3'h7
`define GPMUX_SEL_LOCAL       3'h0
`define GPMUX_SEL_LOCK_OR     3'h1
`define GPMUX_SEL_LOCK_AND    3'h2
`define GPMUX_SEL_PASS_AND    3'h3
`define GPMUX_SEL_SYNC        3'h4
`define GPMUX_SEL_TPASS_AND   3'h0
`define GPMUX_SEL_TPASS_OR    3'h1
`define GPMUX_SEL_TFRAME      3'h2
`define GPMUX_SEL_TLINE       3'h3
`define GPMUX_SEL_TMERGED     3'h4
`define GPMUX_SEL_TIRQ        3'h5

`endif

/* File: gpmux_pkg.sv */
// types shared by the pin output mux
package gpmux_pkg;

    // ------------------------------------------------------------
    // per receive port signals
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] remote_pin;
        logic       lock;
        logic       pass;
        logic       frame_valid;
        logic       line_valid;
    } gpmux_rx_t;

    // ------------------------------------------------------------
    // per transmit port signals
    // ------------------------------------------------------------
    typedef struct packed {
        logic frame_active;
        logic line_active;
        logic merged_sync;
        logic irq;
    } gpmux_tx_t;

    // ------------------------------------------------------------
    // one pin control register
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] signal_select;
        logic [2:0] source_class;
        logic       local_value;
        logic       drive_enable;
    } gpmux_ctl_t;

    typedef enum logic [0:0] {
        GPMUX_IDLE = 1'b0,
        GPMUX_DONE = 1'b1
    } gpmux_bus_t;

endpackage : gpmux_pkg

/* File: gpmux_pin_sel.sv */
// one pin: source class and signal select down to a pin level and enable
`timescale 1ns/1ns
`include "gpmux_defs.svh"

module gpmux_pin_sel
    import gpmux_pkg::*;
(
    // ---- clock and reset
    input  wire logic            mclk_i,
    input  wire logic            rst_n_i,
    // ---- control and sources
    input  wire gpmux_ctl_t      ctl_i,
    input  wire gpmux_rx_t [3:0] rx_i,
    input  wire gpmux_tx_t [1:0] tx_i,
    input  wire logic      [3:0] rx_enable_i,
    input  wire logic      [3:0] tx0_rxsel_i,
    input  wire logic      [3:0] tx1_rxsel_i,
    input  wire logic            sync_pulse_i,
    // ---- pin
    output logic                 pin_o,
    output logic                 pin_oe_o
);

    logic       level_next;
    logic [3:0] lock_v;
    logic [3:0] pass_v;
    logic [3:0] txsel;
    logic       lock_or;
    logic       lock_and;
    logic       pass_and;

    // ------------------------------------------------------------
    // status reductions over enabled ports
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_vec
            assign lock_v[g] = rx_i[g].lock;
            assign pass_v[g] = rx_i[g].pass;
        end
    endgenerate

    // disabled ports count as neutral in an AND, but with no port enabled the AND reads 0
    assign lock_or  = |(lock_v & rx_enable_i);
    assign lock_and = (rx_enable_i != 4'h0) && &(lock_v | ~rx_enable_i);
    assign pass_and = (rx_enable_i != 4'h0) && &(pass_v | ~rx_enable_i);
    assign txsel    = ctl_i.source_class[0] ? tx1_rxsel_i : tx0_rxsel_i;

    // ------------------------------------------------------------
    // selection
    // ------------------------------------------------------------
    always_comb begin
        level_next = 1'b0;
        if (ctl_i.source_class[2] == 1'b0) begin
            case (ctl_i.signal_select)
                `GPMUX_SEL_LOCK: level_next = rx_i[ctl_i.source_class[1:0]].lock;
                `GPMUX_SEL_PASS: level_next = rx_i[ctl_i.source_class[1:0]].pass;
                `GPMUX_SEL_FV:   level_next = rx_i[ctl_i.source_class[1:0]].frame_valid;
                `GPMUX_SEL_LV:   level_next = rx_i[ctl_i.source_class[1:0]].line_valid;
                default:         level_next =
                    rx_i[ctl_i.source_class[1:0]].remote_pin[ctl_i.signal_select[1:0]];
            endcase
        end else if (ctl_i.source_class == `GPMUX_SRC_STATUS) begin
            case (ctl_i.signal_select)
                `GPMUX_SEL_LOCAL:    level_next = ctl_i.local_value;
                `GPMUX_SEL_LOCK_OR:  level_next = lock_or;
                `GPMUX_SEL_LOCK_AND: level_next = lock_and;
                `GPMUX_SEL_PASS_AND: level_next = pass_and;
                `GPMUX_SEL_SYNC:     level_next = sync_pulse_i;
                default:             level_next = 1'b0;
            endcase
        end else if (ctl_i.source_class != `GPMUX_SRC_RSVD) begin
            case (ctl_i.signal_select)
                `GPMUX_SEL_TPASS_AND: level_next = (txsel != 4'h0) && &(pass_v | ~txsel);
                `GPMUX_SEL_TPASS_OR:  level_next = |(pass_v & txsel);
                `GPMUX_SEL_TFRAME:    level_next = tx_i[ctl_i.source_class[0]].frame_active;
                `GPMUX_SEL_TLINE:     level_next = tx_i[ctl_i.source_class[0]].line_active;
                `GPMUX_SEL_TMERGED:   level_next = tx_i[ctl_i.source_class[0]].merged_sync;
                `GPMUX_SEL_TIRQ:      level_next = tx_i[ctl_i.source_class[0]].irq;
                default:              level_next = 1'b0;
            endcase
        end
    end

    // registered so the pin sees no decode glitches; costs one cycle
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            pin_o    <= 1'b0;
            pin_oe_o <= 1'b0;
        end else begin
            pin_o    <= ctl_i.drive_enable ? level_next : 1'b0;
            pin_oe_o <= ctl_i.drive_enable;
        end
    end

endmodule : gpmux_pin_sel

/* File: gpmux_top.sv */
// pin 3 and pin 4 output source multiplexers with an avalon-mm register slave
`timescale 1ns/1ns
`include "gpmux_defs.svh"

module gpmux_top
    import gpmux_pkg::*;
(
    // ---- clock and reset
    input  wire logic            mclk_i,
    input  wire logic            rst_n_i,
    // ---- avalon-mm slave
    input  wire logic [9:0]      avs_address_i,
    input  wire logic            avs_read_i,
    input  wire logic            avs_write_i,
    input  wire logic [31:0]     avs_writedata_i,
    input  wire logic [3:0]      avs_byteenable_i,
    output logic      [31:0]     avs_readdata_o,
    output logic                 avs_waitrequest_o,
    // ---- signal sources
    input  wire gpmux_rx_t [3:0] rx_i,
    input  wire gpmux_tx_t [1:0] tx_i,
    input  wire logic            camera_sync_pulse_i,
    // ---- pins
    output logic                 pin3_o,
    output logic                 pin3_oe_o,
    output logic                 pin4_o,
    output logic                 pin4_oe_o
);

    gpmux_ctl_t  pin3_output_control_reg;
    gpmux_ctl_t  pin4_output_control_reg;
    logic [3:0]  rx_enable_reg;
    logic [3:0]  tx0_rxsel_reg;
    logic [3:0]  tx1_rxsel_reg;
    gpmux_bus_t  bus_state_reg;
    gpmux_bus_t  bus_state_next;
    logic [31:0] readdata_next;
    logic        access;
    logic        wr_take;
    logic [7:0]  idx;

    // ------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------
    // one wait cycle per access: the answer lands on the second edge
    assign access            = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = access && (bus_state_reg == GPMUX_IDLE);
    // write commits only at the edge where waitrequest is seen low
    assign wr_take           = avs_write_i && (bus_state_reg == GPMUX_DONE) && avs_byteenable_i[0];
    assign idx               = avs_address_i[9:2];

    always_comb begin
        case (bus_state_reg)
            GPMUX_IDLE: bus_state_next = access ? GPMUX_DONE : GPMUX_IDLE;
            GPMUX_DONE: bus_state_next = GPMUX_IDLE;
            default:    bus_state_next = GPMUX_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            bus_state_reg <= GPMUX_IDLE;
        end else begin
            bus_state_reg <= bus_state_next;
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            pin3_output_control_reg <= `GPMUX_CTL_RESET;
            pin4_output_control_reg <= `GPMUX_CTL_RESET;
        end else if (wr_take) begin
            if (idx == `GPMUX_IDX_PIN3_CTL) begin
                pin3_output_control_reg <= avs_writedata_i[7:0];
            end
            if (idx == `GPMUX_IDX_PIN4_CTL) begin
                pin4_output_control_reg <= avs_writedata_i[7:0];
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            rx_enable_reg <= `GPMUX_RXEN_RESET;
            tx0_rxsel_reg <= `GPMUX_TXSEL_RESET;
            tx1_rxsel_reg <= `GPMUX_TXSEL_RESET;
        end else if (wr_take) begin
            if (idx == `GPMUX_IDX_RX_ENABLE) begin
                rx_enable_reg <= avs_writedata_i[3:0];
            end
            if (idx == `GPMUX_IDX_TX0_RXSEL) begin
                tx0_rxsel_reg <= avs_writedata_i[3:0];
            end
            if (idx == `GPMUX_IDX_TX1_RXSEL) begin
                tx1_rxsel_reg <= avs_writedata_i[3:0];
            end
        end
    end

    // ------------------------------------------------------------
    // read path; unmapped words read as zero
    // ------------------------------------------------------------
    always_comb begin
        readdata_next = 32'h0000_0000;
        case (idx)
            `GPMUX_IDX_PIN3_CTL:   readdata_next[7:0] = pin3_output_control_reg;
            `GPMUX_IDX_PIN4_CTL:   readdata_next[7:0] = pin4_output_control_reg;
            `GPMUX_IDX_RX_ENABLE:  readdata_next[3:0] = rx_enable_reg;
            `GPMUX_IDX_TX0_RXSEL:  readdata_next[3:0] = tx0_rxsel_reg;
            `GPMUX_IDX_TX1_RXSEL:  readdata_next[3:0] = tx1_rxsel_reg;
            `GPMUX_IDX_PIN_STATUS: readdata_next[3:0] = {pin4_oe_o, pin4_o, pin3_oe_o, pin3_o};
            default:               readdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i && (bus_state_reg == GPMUX_IDLE)) begin
            avs_readdata_o <= readdata_next;
        end
    end

    // ------------------------------------------------------------
    // pin multiplexers
    // ------------------------------------------------------------
    gpmux_pin_sel u_pin3 (
        .mclk_i       (mclk_i),
        .rst_n_i      (rst_n_i),
        .ctl_i        (pin3_output_control_reg),
        .rx_i         (rx_i),
        .tx_i         (tx_i),
        .rx_enable_i  (rx_enable_reg),
        .tx0_rxsel_i  (tx0_rxsel_reg),
        .tx1_rxsel_i  (tx1_rxsel_reg),
        .sync_pulse_i (camera_sync_pulse_i),
        .pin_o        (pin3_o),
        .pin_oe_o     (pin3_oe_o)
    );

    gpmux_pin_sel u_pin4 (
        .mclk_i       (mclk_i),
        .rst_n_i      (rst_n_i),
        .ctl_i        (pin4_output_control_reg),
        .rx_i         (rx_i),
        .tx_i         (tx_i),
        .rx_enable_i  (rx_enable_reg),
        .tx0_rxsel_i  (tx0_rxsel_reg),
        .tx1_rxsel_i  (tx1_rxsel_reg),
        .sync_pulse_i (camera_sync_pulse_i),
        .pin_o        (pin4_o),
        .pin_oe_o     (pin4_oe_o)
    );

endmodule : gpmux_top

/* File: gpmux_checker.sv */
// concurrent checks on the pin mux top-level ports
`timescale 1ns/1ns

module gpmux_checker
    import gpmux_pkg::*;
(
    // ---- clock and reset
    input wire logic        mclk_i,
    input wire logic        rst_n_i,
    // ---- bus
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    // ---- pins
    input wire logic        pin3_o,
    input wire logic        pin3_oe_o,
    input wire logic        pin4_o,
    input wire logic        pin4_oe_o
);
    logic wr_done;

    assign wr_done = avs_write_i & ~avs_waitrequest_o;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    // ------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------
    sequence s_one_wait;
        avs_waitrequest_o ##1 !avs_waitrequest_o;
    endsequence

    a_read_one_wait: assert property ($rose(avs_read_i) |-> s_one_wait)
        else $error("read did not take exactly one wait cycle");
    a_write_one_wait: assert property ($rose(avs_write_i) |-> s_one_wait)
        else $error("write did not take exactly one wait cycle");
    a_idle_no_wait: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
        else $error("waitrequest high while idle");
    a_rdata_by_read: assert property ($changed(avs_readdata_o) |-> $past(avs_read_i))
        else $error("read data moved without a read");

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    a_pin3_off_low: assert property (!pin3_oe_o |-> !pin3_o)
        else $error("pin3 high with driver off");
    a_pin4_off_low: assert property (!pin4_oe_o |-> !pin4_o)
        else $error("pin4 high with driver off");
    // enable bits move only two edges after a completed write
    a_oe3_by_write: assert property ($changed(pin3_oe_o) |-> $past(wr_done, 2))
        else $error("pin3 enable moved without a write");
    a_oe4_by_write: assert property ($changed(pin4_oe_o) |-> $past(wr_done, 2))
        else $error("pin4 enable moved without a write");
    a_reset_quiet: assert property (disable iff (1'b0)
        !rst_n_i |=> !pin3_oe_o && !pin4_oe_o && avs_readdata_o == 32'h0)
        else $error("outputs not cleared by reset");
endmodule : gpmux_checker

bind gpmux_top gpmux_checker gpmux_checker_i (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .pin3_o(pin3_o), .pin3_oe_o(pin3_oe_o), .pin4_o(pin4_o), .pin4_oe_o(pin4_oe_o));

/* File: gpmux_board.sv */
// board side of the two output pins, with pull-downs
`timescale 1ns/1ns

module gpmux_board (
    // ---- pins from the device
    input  wire logic       pin3_i,
    input  wire logic       pin3_oe_i,
    input  wire logic       pin4_i,
    input  wire logic       pin4_oe_i,
    // ---- levels seen on the board
    output logic      [1:0] level_o
);
    // an undriven pin is pulled low, never left at the last level
    assign level_o = {pin4_oe_i ? pin4_i : 1'b0, pin3_oe_i ? pin3_i : 1'b0};
endmodule : gpmux_board

/* File: gpmux_top_tb.sv */
// self-checking bench for the pin output mux
`timescale 1ns/1ns
`include "gpmux_defs.svh"

module gpmux_top_tb;
    import gpmux_pkg::*;
    localparam logic [9:0] A3  = {`GPMUX_IDX_PIN3_CTL, 2'b00};
    localparam logic [9:0] A4  = {`GPMUX_IDX_PIN4_CTL, 2'b00};
    localparam logic [9:0] AEN = {`GPMUX_IDX_RX_ENABLE, 2'b00};
    localparam logic [9:0] AT0 = {`GPMUX_IDX_TX0_RXSEL, 2'b00};
    localparam logic [9:0] AT1 = {`GPMUX_IDX_TX1_RXSEL, 2'b00};
    localparam logic [9:0] AST = {`GPMUX_IDX_PIN_STATUS, 2'b00};
    logic                 mclk_i = 1'b0;
    logic                 rst_n_i = 1'b0;
    logic                 rd = 1'b0;
    logic                 wr = 1'b0;
    logic           [9:0] addr = 10'h0;
    logic          [31:0] wdata = 32'h0;
    logic           [3:0] be = 4'h0;
    logic          [31:0] rdata;
    logic          [31:0] got;
    logic                 wait_o, p3, p3oe, p4, p4oe;
    logic           [1:0] lvl;
    logic           [3:0] ev, rxen, t0sel, t1sel;
    gpmux_rx_t      [3:0] rx = '0;
    gpmux_tx_t      [1:0] tx = '0;
    logic                 sync = 1'b0;
    gpmux_ctl_t           c3, c4;
    integer               seed = 32'h0A04;
    integer               n_errors = 0;
    integer               total_checks = 0;
    logic          [31:0] r;

    gpmux_top gpmux_top_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address_i(addr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wait_o), .rx_i(rx), .tx_i(tx), .camera_sync_pulse_i(sync),
        .pin3_o(p3), .pin3_oe_o(p3oe), .pin4_o(p4), .pin4_oe_o(p4oe));
    gpmux_board gpmux_board_i (.pin3_i(p3), .pin3_oe_i(p3oe), .pin4_i(p4), .pin4_oe_i(p4oe), .level_o(lvl));

    initial forever #4 mclk_i = ~mclk_i;

    // ------------------------------------------------------------
    // checking and bus tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up;
        if (n_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up

    // request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [3:0] b);
        integer n;
        n = 0;
        addr  <= a;
        wdata <= d;
        be    <= b;
        rd    <= !w;
        wr    <= w;
        do begin
            @(posedge mclk_i);
            n++;
        end while (wait_o !== 1'b0 && n < 20);
        if (wait_o !== 1'b0) begin
            n_errors++;
            wrap_up;
        end else begin
            got = rdata;
            rd <= 1'b0;
            wr <= 1'b0;
            @(posedge mclk_i);
        end
    endtask : bus

    function automatic logic exp_lvl(input gpmux_ctl_t c);
        logic      [3:0] lk, ps, s;
        logic            v;
        gpmux_rx_t       p;
        gpmux_tx_t       t;
        for (int i = 0; i < 4; i++) begin
            lk[i] = rx[i].lock;
            ps[i] = rx[i].pass;
        end
        p = rx[c.source_class[1:0]];
        t = tx[c.source_class[0]];
        s = c.source_class[0] ? t1sel : t0sel;
        v = 1'b0;
        if (!c.source_class[2]) begin
            case (c.signal_select)
                3'h4: v = p.lock;
                3'h5: v = p.pass;
                3'h6: v = p.frame_valid;
                3'h7: v = p.line_valid;
                default: v = p.remote_pin[c.signal_select[1:0]];
            endcase
        end else if (c.source_class == 3'h4) begin
            case (c.signal_select)
                3'h0: v = c.local_value;
                3'h1: v = |(lk & rxen);
                3'h2: v = (rxen != 4'h0) && ((lk & rxen) == rxen);
                3'h3: v = (rxen != 4'h0) && ((ps & rxen) == rxen);
                3'h4: v = sync;
                default: v = 1'b0;
            endcase
        end else if (c.source_class[1]) begin
            case (c.signal_select)
                3'h0: v = (s != 4'h0) && ((ps & s) == s);
                3'h1: v = |(ps & s);
                3'h2: v = t.frame_active;
                3'h3: v = t.line_active;
                3'h4: v = t.merged_sync;
                3'h5: v = t.irq;
                default: v = 1'b0;
            endcase
        end
        return c.drive_enable & v;
    endfunction : exp_lvl

    initial begin
        repeat (100000) @(posedge mclk_i);
        n_errors++;
        wrap_up;
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        bus(1'b0, A3, 32'h0, 4'hF);
        check(got, 32'h0);
        bus(1'b0, A4, 32'h0, 4'hF);
        check(got, 32'h0);
        bus(1'b0, AEN, 32'h0, 4'hF);
        check(got, 32'hF);
        bus(1'b0, AT0, 32'h0, 4'hF);
        check(got, 32'hF);
        bus(1'b0, AT1, 32'h0, 4'hF);
        check(got, 32'hF);
        bus(1'b0, 10'h090, 32'h0, 4'hF);
        check(got, 32'h0);
        bus(1'b1, A3, 32'hFF, 4'h0);
        bus(1'b0, A3, 32'h0, 4'hF);
        check(got, 32'h0);
        // every control code on pin 3, random codes on pin 4
        for (int k = 0; k < 256; k++) begin
            r = $random(seed);
            rx <= r;
            r = $random(seed);
            tx <= r[7:0];
            sync <= r[8];
            rxen = r[12:9];
            t0sel = r[16:13];
            t1sel = r[20:17];
            c3 = k[7:0];
            c4 = r[31:24];
            bus(1'b1, AEN, {28'h0, rxen}, 4'hF);
            bus(1'b1, AT0, {28'h0, t0sel}, 4'hF);
            bus(1'b1, AT1, {28'h0, t1sel}, 4'hF);
            bus(1'b1, A3, {24'h0, c3}, 4'hF);
            bus(1'b1, A4, {24'h0, c4}, 4'hF);
            repeat (3) @(posedge mclk_i);
            ev = {c4.drive_enable, exp_lvl(c4), c3.drive_enable, exp_lvl(c3)};
            check({28'h0, p4oe, p4, p3oe, p3}, {28'h0, ev});
            check({30'h0, lvl}, {30'h0, ev[2], ev[0]});
            bus(1'b0, A3, 32'h0, 4'hF);
            check(got, {24'h0, c3});
            bus(1'b0, AST, 32'h0, 4'hF);
            check(got, {28'h0, ev});
        end
        rst_n_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        check({28'h0, p4oe, p4, p3oe, p3}, 32'h0);
        bus(1'b0, A4, 32'h0, 4'hF);
        check(got, 32'h0);
        wrap_up;
    end
endmodule : gpmux_top_tb
